/* include/bblp_pkg.sv */
/*
  Package for the sounder and backlight policy block: register map, field
  layout, reset values, encodings and timing constants.
  Assumes a 200 MHz APB clock and a 32-bit APB master.
*/
// How it works
// - Continuous request beats intermittent request
// - Full enable: command, screen attribute, error sound
// - Error-only: only errors and self-test sound
// - Off: silent for every request source but self-test
// - Self-test sounds regardless of policy
// - Store init sets sounder policy full
// - Touch or screen change wakes dimmed backlight
// - Value updates neither wake nor restart idle
// - Short timeout: dim after 10 minutes idle
// - Long timeout: dim after 1 hour idle
// - Timeout disabled: backlight stays on forever
// - Store init sets timeout to 10 minutes
// - Menu edits staged; commit writes, quit discards
// - Sounder selector cycles full, error-only, off
package bblp_pkg;
  localparam logic [7:0] ADDR_STORED = 8'h00;
  localparam logic [7:0] ADDR_STAGED = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_REQ    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int SND_LSB  = 0;
  localparam int BKL_LSB  = 2;
  localparam int CMD_SND_SEL = 0;
  localparam int CMD_BKL_SEL = 1;
  localparam int CMD_COMMIT  = 2;
  localparam int CMD_QUIT    = 3;
  localparam int CMD_INIT    = 4;
  localparam int REQ_CONT    = 0;
  localparam int REQ_INTER   = 1;
  localparam int REQ_SCREEN  = 2;
  localparam int REQ_TEST    = 3;
  localparam int REQ_ERROR   = 4;
  typedef enum logic [1:0] {
    BBLP_SND_FULL = 2'h0,
    BBLP_SND_ERR  = 2'h1,
    BBLP_SND_OFF  = 2'h2
  } bblp_snd_t;
  typedef enum logic [1:0] {
    BBLP_BKL_SHORT = 2'h0,
    BBLP_BKL_LONG  = 2'h1,
    BBLP_BKL_NONE  = 2'h2
  } bblp_bkl_t;
  localparam bblp_snd_t SND_RESET = BBLP_SND_FULL;
  localparam bblp_bkl_t BKL_RESET = BBLP_BKL_SHORT;
  localparam longint CLK_HZ         = 200000000;
  localparam longint SHORT_MIN      = 10;
  localparam longint LONG_HOUR      = 1;
  localparam longint SHORT_CYCLES   = SHORT_MIN * 60 * CLK_HZ;
  localparam longint LONG_CYCLES    = LONG_HOUR * 3600 * CLK_HZ;
  localparam longint BEEP_HALF_MS   = 250;
  localparam longint BEEP_CYCLES    = BEEP_HALF_MS * CLK_HZ / 1000;
endpackage : bblp_pkg

/* rtl/bblp_top.sv */
/*
  Sounder and backlight policy block with an APB register slave.
  Assumes pulse inputs from same-clock logic, a touch level from a pin,
  and that the register file stands for the nonvolatile store.
*/
// The APB register port and the placing of the registers were chosen for this implementation.
module bblp_top #(
  parameter longint SHORT_TICKS = bblp_pkg::SHORT_CYCLES,
  parameter longint LONG_TICKS  = bblp_pkg::LONG_CYCLES,
  parameter longint BEEP_TICKS  = bblp_pkg::BEEP_CYCLES
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        clk_en,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire  logic        touch_pin,
  input  wire  logic        screen_change,
  input  wire  logic        value_update,
  output logic              sounder,
  output logic              backlight
);
  import bblp_pkg::*;

  // Counters are sized for the hour timeout; longer spans need wider ones
  if (SHORT_TICKS < 2 || LONG_TICKS < 2 || BEEP_TICKS < 1 ||
      SHORT_TICKS > 64'h0000_0100_0000_0000 ||
      LONG_TICKS > 64'h0000_0100_0000_0000 ||
      BEEP_TICKS > 64'h0000_0001_0000_0000) begin : g_bad_ticks
    $error("bblp_top: timing counts out of range");
  end

  bblp_snd_t   stored_snd;
  bblp_bkl_t   stored_bkl;
  bblp_snd_t   staged_snd;
  bblp_bkl_t   staged_bkl;
  logic [4:0]  req;
  logic [2:0]  touch_sync;
  logic        touch_level;
  logic        touch_prev;
  logic [39:0] idle_cnt;
  logic [31:0] beep_cnt;
  logic        beep_phase;
  logic        next_sounder;
  logic        wr;
  logic        rd;

  function automatic bblp_snd_t snd_step(input bblp_snd_t v);
    unique case (v)
      BBLP_SND_FULL: snd_step = BBLP_SND_ERR;
      BBLP_SND_ERR:  snd_step = BBLP_SND_OFF;
      default:       snd_step = BBLP_SND_FULL;
    endcase
  endfunction : snd_step

  function automatic bblp_bkl_t bkl_step(input bblp_bkl_t v);
    unique case (v)
      BBLP_BKL_SHORT: bkl_step = BBLP_BKL_LONG;
      BBLP_BKL_LONG:  bkl_step = BBLP_BKL_NONE;
      default:        bkl_step = BBLP_BKL_SHORT;
    endcase
  endfunction : bkl_step

  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && pready;

  // One wait state keeps read data registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready &&
                 !(paddr == ADDR_STORED || paddr == ADDR_STAGED ||
                   paddr == ADDR_CMD || paddr == ADDR_REQ ||
                   paddr == ADDR_STATUS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (clk_en && psel && penable && !pwrite && !pready) begin
      unique case (paddr)
        ADDR_STORED: prdata <= {28'h0, stored_bkl, stored_snd};
        ADDR_STAGED: prdata <= {28'h0, staged_bkl, staged_snd};
        ADDR_REQ:    prdata <= {27'h0, req};
        ADDR_STATUS: prdata <= {30'h0, backlight, sounder};
        default:     prdata <= 32'h0;
      endcase
    end
  end

  // Staged copies let the menu be abandoned without touching the store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_snd <= SND_RESET;
      stored_bkl <= BKL_RESET;
      staged_snd <= SND_RESET;
      staged_bkl <= BKL_RESET;
    end else if (clk_en && wr && paddr == ADDR_CMD) begin
      if (pwdata[CMD_INIT]) begin
        stored_snd <= SND_RESET;
        stored_bkl <= BKL_RESET;
        staged_snd <= SND_RESET;
        staged_bkl <= BKL_RESET;
      end else if (pwdata[CMD_COMMIT]) begin
        stored_snd <= staged_snd;
        stored_bkl <= staged_bkl;
      end else if (pwdata[CMD_QUIT]) begin
        staged_snd <= stored_snd;
        staged_bkl <= stored_bkl;
      end else begin
        if (pwdata[CMD_SND_SEL])
          staged_snd <= snd_step(staged_snd);
        if (pwdata[CMD_BKL_SEL])
          staged_bkl <= bkl_step(staged_bkl);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 5'h0;
    end else if (clk_en && wr && paddr == ADDR_REQ) begin
      req <= pwdata[4:0];
    end
  end

  // Intermittent tone period is free-running, not tied to request start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beep_cnt   <= 32'h0;
      beep_phase <= 1'b0;
    end else if (clk_en) begin
      if (beep_cnt >= 32'(BEEP_TICKS - 1)) begin
        beep_cnt   <= 32'h0;
        beep_phase <= !beep_phase;
      end else begin
        beep_cnt <= beep_cnt + 32'h1;
      end
    end
  end

  always_comb begin
    logic host_on;
    host_on = req[REQ_CONT] || (req[REQ_INTER] && beep_phase);
    next_sounder = 1'b0;
    unique case (stored_snd)
      BBLP_SND_FULL: next_sounder = host_on || req[REQ_SCREEN] ||
                                    req[REQ_ERROR];
      BBLP_SND_ERR:  next_sounder = req[REQ_ERROR];
      default:       next_sounder = 1'b0;
    endcase
    if (req[REQ_TEST])
      next_sounder = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sounder <= 1'b0;
    end else if (clk_en) begin
      sounder <= next_sounder;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_sync <= 3'h0;
      touch_level <= 1'b0;
      touch_prev <= 1'b0;
    end else if (clk_en) begin
      touch_sync <= {touch_sync[1:0], touch_pin};
      if (touch_sync[2] == touch_sync[1])
        touch_level <= touch_sync[2];
      touch_prev <= touch_level;
    end
  end

  // Value updates are deliberately not an input to the idle logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt  <= 40'h0;
      backlight <= 1'b1;
    end else if (clk_en) begin
      if ((touch_level && !touch_prev) || screen_change) begin
        idle_cnt  <= 40'h0;
        backlight <= 1'b1;
      end else if (stored_bkl == BBLP_BKL_NONE) begin
        idle_cnt  <= 40'h0;
        backlight <= 1'b1;
      end else if (stored_bkl == BBLP_BKL_SHORT &&
                   idle_cnt >= 40'(SHORT_TICKS - 1)) begin
        backlight <= 1'b0;
      end else if (stored_bkl == BBLP_BKL_LONG &&
                   idle_cnt >= 40'(LONG_TICKS - 1)) begin
        backlight <= 1'b0;
      end else begin
        idle_cnt <= idle_cnt + 40'h1;
      end
    end
  end

  sequence s_screen;
    clk_en && screen_change;
  endsequence

  sequence s_press;
    clk_en && touch_level && !touch_prev;
  endsequence

  sequence s_woken;
    backlight && idle_cnt == 40'h0;
  endsequence

  chk_test_forces_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && req[REQ_TEST] |=> sounder)
    else $error("test not sounding");

  chk_off_silent: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && stored_snd == BBLP_SND_OFF && !req[REQ_TEST] |=> !sounder)
    else $error("sounder not silent when off");

  chk_err_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && stored_snd == BBLP_SND_ERR && !req[REQ_TEST] |=>
    sounder == $past(req[REQ_ERROR]))
    else $error("error-only wrong");

  chk_cont_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && stored_snd == BBLP_SND_FULL && req[REQ_CONT] |=> sounder)
    else $error("continuous not sounding");

  chk_full_sources: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && stored_snd == BBLP_SND_FULL &&
    (req[REQ_SCREEN] || req[REQ_ERROR]) |=> sounder)
    else $error("full enable source ignored");

  // Both wake sources restart the idle count as well as lighting up
  chk_wake_screen: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_screen |=> s_woken)
    else $error("screen change did not wake");

  chk_wake_press: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_press |=> s_woken)
    else $error("touch press did not wake");

  chk_none_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && stored_bkl == BBLP_BKL_NONE |=> backlight)
    else $error("backlight off with timeout disabled");

  chk_short_dim: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && stored_bkl == BBLP_BKL_SHORT && !screen_change &&
    !(touch_level && !touch_prev) && idle_cnt >= 40'(SHORT_TICKS - 1)
    |=> !backlight)
    else $error("short timeout did not dim");

  chk_long_dim: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && stored_bkl == BBLP_BKL_LONG && !screen_change &&
    !(touch_level && !touch_prev) && idle_cnt >= 40'(LONG_TICKS - 1)
    |=> !backlight)
    else $error("long timeout did not dim");

  chk_value_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && value_update && !backlight && !screen_change &&
    !(touch_level && !touch_prev) && stored_bkl != BBLP_BKL_NONE
    |=> !backlight)
    else $error("value update woke backlight");

  chk_quit_restores: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == ADDR_CMD && pwdata[CMD_QUIT] &&
    pwdata[4:2] == 3'h2 |=> staged_snd == stored_snd)
    else $error("quit did not discard");

  chk_snd_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == ADDR_CMD && pwdata[4:0] == 5'h01 &&
    staged_snd == BBLP_SND_OFF |=> staged_snd == BBLP_SND_FULL)
    else $error("sounder selector did not wrap");

  chk_bkl_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == ADDR_CMD && pwdata[4:0] == 5'h02 &&
    staged_bkl == BBLP_BKL_SHORT |=> staged_bkl == BBLP_BKL_LONG)
    else $error("timeout selector wrong");

  chk_init_defaults: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == ADDR_CMD && pwdata[CMD_INIT] |=>
    stored_snd == BBLP_SND_FULL && stored_bkl == BBLP_BKL_SHORT)
    else $error("init defaults wrong");

  chk_beep_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && beep_cnt >= 32'(BEEP_TICKS - 1) |=>
    beep_phase != $past(beep_phase))
    else $error("intermittent phase stuck");

  // A low clock enable must hold every output where it stands
  chk_freeze_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clk_en |=> sounder == $past(sounder) &&
    backlight == $past(backlight) && pready == $past(pready))
    else $error("state moved while frozen");
endmodule : bblp_top

/* sim/bblp_host_model.sv */
/*
  Host and touch panel model: screen change and value update pulses,
  touch presses. Assumes the bench's pclk as its only clock.
*/
module bblp_host_model (
  input  wire logic pclk,
  output logic      touch_pin,
  output logic      screen_change,
  output logic      value_update
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    touch_pin = 1'b0;
    screen_change = 1'b0;
    value_update = 1'b0;
  end

  // One clock wide, since the block samples these on pclk
  task automatic pulse(input bit scr);
    @(posedge pclk);
    if (scr)
      screen_change <= 1'b1;
    else
      value_update <= 1'b1;
    @(posedge pclk);
    screen_change <= 1'b0;
    value_update <= 1'b0;
  endtask : pulse

  // Held past the three-flop synchroniser so the press is seen
  task automatic press();
    @(posedge pclk);
    touch_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    touch_pin <= 1'b0;
  endtask : press
endmodule : bblp_host_model

/* sim/bblp_top_tb.sv */
/*
  Bench for the sounder and backlight policy block: APB master, policy
  table, backlight timing. Assumes shortened timeout parameters.
*/
module bblp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bblp_pkg::*;
  localparam int SHORT = 20;
  localparam int LONG  = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        clk_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        touch_pin, screen_change, value_update, sounder, backlight;
  int          bad_count = 0;
  int          total_checks = 0;
  int          n;
  // Rows: selector presses, request word, high cycles out of 16
  int r_sel[12] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 0};
  int r_req[12] = '{1, 4, 16, 3, 1, 4, 16, 16, 1, 8, 1, 2};
  int r_cnt[12] = '{16, 16, 16, 16, 0, 0, 16, 0, 0, 16, 16, 8};

  bblp_top #(.SHORT_TICKS(SHORT), .LONG_TICKS(LONG), .BEEP_TICKS(4)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .touch_pin(touch_pin), .screen_change(screen_change),
    .value_update(value_update), .sounder(sounder), .backlight(backlight));

  bblp_host_model host (.pclk(pclk), .touch_pin(touch_pin),
    .screen_change(screen_change), .value_update(value_update));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (k >= 20)
      chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic cmd(input int b);
    apb(1'b1, ADDR_CMD, 32'h1 << b);
  endtask : cmd

  task automatic count(output int c);
    c = 0;
    repeat (16) begin
      @(posedge pclk);
      if (sounder === 1'b1)
        c++;
    end
  endtask : count

  // A value update midway must not restart the idle count
  task automatic dim(input int t);
    int k;
    host.pulse(1'b1);
    repeat (2) @(posedge pclk);
    k = 3;
    while (backlight !== 1'b0 && k < 400) begin
      @(posedge pclk);
      k++;
      if (k == 8)
        fork host.pulse(1'b0); join_none
    end
    chk(32'(k >= t - 1 && k <= t + 3), 32'h1);
  endtask : dim

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    chk({30'h0, sounder, backlight}, 32'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_STORED, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 12; i++) begin
      cmd(CMD_INIT);
      repeat (r_sel[i]) cmd(CMD_SND_SEL);
      cmd(CMD_COMMIT);
      apb(1'b0, ADDR_STORED, 32'h0);
      chk({30'h0, rd[1:0]}, 32'(r_sel[i] % 3));
      apb(1'b1, ADDR_REQ, 32'(r_req[i]));
      repeat (2) @(posedge pclk);
      count(n);
      chk(32'(n), 32'(r_cnt[i]));
      apb(1'b0, ADDR_REQ, 32'h0);
      chk(rd, 32'(r_req[i]));
    end
    apb(1'b1, ADDR_REQ, 32'h0);
    cmd(CMD_INIT);
    cmd(CMD_SND_SEL);
    cmd(CMD_QUIT);
    apb(1'b0, ADDR_STORED, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_STAGED, 32'h0);
    chk(rd, 32'h0);
    dim(SHORT);
    host.pulse(1'b0);
    repeat (4) @(posedge pclk);
    chk({31'h0, backlight}, 32'h0);
    host.press();
    repeat (4) @(posedge pclk);
    chk({31'h0, backlight}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h2);
    // A frozen idle count must outlast the short timeout without dimming
    clk_en <= 1'b0;
    repeat (2 * SHORT) @(posedge pclk);
    chk({31'h0, backlight}, 32'h1);
    clk_en <= 1'b1;
    host.pulse(1'b1);
    for (int m = 1; m <= 3; m++) begin
      cmd(CMD_BKL_SEL);
      cmd(CMD_COMMIT);
      apb(1'b0, ADDR_STORED, 32'h0);
      chk({30'h0, rd[3:2]}, 32'(m % 3));
      if (m == 1)
        dim(LONG);
      if (m == 2) begin
        host.pulse(1'b1);
        repeat (3 * LONG) @(posedge pclk);
        chk({31'h0, backlight}, 32'h1);
      end
    end
    conclude();
  end
endmodule : bblp_top_tb
